// ==== logic/mashm_top.sv ====
`timescale 1ns/1ps

module mashm_top (
   input  wire logic       mclk_i,
   input  wire logic       rst_i,
   input  wire logic       scl_i,
   input  wire logic       sda_i,
   output logic            sda_o,
   output logic            sda_oe_o,
   input  wire logic [2:0] addr_pins_i,
   input  wire logic [6:0] channel_exceed_i,
   input  wire logic       hot_temp_exceed_i,
   input  wire logic       overtemp_exceed_i,
   input  wire logic       tach_input_1_count_exceed_i,
   input  wire logic       tach_input_2_count_exceed_i,
   input  wire logic       ext_alarm_n_i,
   input  wire logic       digital_sensor_alert_input_n_i,
   input  wire logic       chassis_intrusion_input_i,
   input  wire logic       tach_input_1_i,
   input  wire logic       tach_input_2_i,
   input  wire logic       alarm_out_enable_i,
   input  wire logic       alarm_polarity_i,
   input  wire logic       alarm_clear_i,
   input  wire logic       reset_out_request_i,
   output logic            alarm_o,
   output logic            alarm_oe_o,
   output logic            shared_pin_o,
   output logic            shared_pin_oe_o,
   output logic            monitor_pause_o,
   output logic [1:0]      tach_mode_o,
   output logic [1:0]      tach1_code_o,
   output logic [1:0]      tach2_code_o
);
   import mashm_pkg::*;

   // All state of the block in one record.
   typedef struct packed {
      mashm_bus_state_type state;
      logic       scl_m;
      logic       scl_s;
      logic       scl_d;
      logic       sda_m;
      logic       sda_s;
      logic       sda_d;
      logic [2:0] addr_m;
      logic [2:0] addr_s;
      logic       ext_m;
      logic       ext_s;
      logic       dig_m;
      logic       dig_s;
      logic       chas_m;
      logic       chas_s;
      logic       tach1_m;
      logic       tach1_s;
      logic       tach2_m;
      logic       tach2_s;
      logic [2:0] bit_cnt;
      logic       byte_done;
      logic       rw;
      logic       master_ack;
      logic [7:0] rx;
      logic [7:0] tx;
      logic [7:0] ptr;
      logic [7:0] chan_status;
      logic [7:0] misc_status;
      logic [7:0] chan_mask;
      logic [7:0] misc_mask;
      logic [7:0] tach_cfg;
      logic       hot_prev;
      logic       ot_prev;
      logic       sda_out;
      logic       sda_oe;
      logic       alarm_out;
      logic       alarm_oe;
      logic       shared_oe;
      logic       pause;
   } mashm_state_type;

   mashm_state_type r;
   mashm_state_type next_r;

   // A tach pin in level mode is active low only for the one code, else high.
   function automatic logic tach_level_active(input logic [1:0] code, input logic level);
      tach_level_active = (code == TACH_LEVEL_ACTIVE_LOW) ? ~level : level;
   endfunction

   logic       scl_rise;
   logic       scl_fall;
   logic       bus_start;
   logic       bus_stop;
   logic       do_load;
   logic       clr_chan;
   logic       clr_misc;
   logic [7:0] rd_data;
   logic [7:0] chan_ev;
   logic [7:0] misc_ev;
   logic       hot_one_time;
   logic       ot_one_time;
   logic       alarm_pending;
   logic       ot_assert;

   // Next-state logic: synchronisers, two-wire slave, flags and pin drive.
   always_comb begin
      next_r = r;
      do_load = 1'b0;
      clr_chan = 1'b0;
      clr_misc = 1'b0;
      chan_ev = BYTE_ZERO;
      misc_ev = BYTE_ZERO;

      // Bus pins pass three flops; address, alarm, sensor, chassis and tach pins two; exceed inputs are unsynchronised. Edges compare stages two and three.
      next_r.scl_m   = scl_i;
      next_r.scl_s   = r.scl_m;
      next_r.scl_d   = r.scl_s;
      next_r.sda_m   = sda_i;
      next_r.sda_s   = r.sda_m;
      next_r.sda_d   = r.sda_s;
      next_r.addr_m  = addr_pins_i;
      next_r.addr_s  = r.addr_m;
      next_r.ext_m   = ext_alarm_n_i;
      next_r.ext_s   = r.ext_m;
      next_r.dig_m   = digital_sensor_alert_input_n_i;
      next_r.dig_s   = r.dig_m;
      next_r.chas_m  = chassis_intrusion_input_i;
      next_r.chas_s  = r.chas_m;
      next_r.tach1_m = tach_input_1_i;
      next_r.tach1_s = r.tach1_m;
      next_r.tach2_m = tach_input_2_i;
      next_r.tach2_s = r.tach2_m;

      scl_rise  = r.scl_s & ~r.scl_d;
      scl_fall  = ~r.scl_s & r.scl_d;
      bus_start = r.scl_s & r.scl_d & r.sda_d & ~r.sda_s;
      bus_stop  = r.scl_s & r.scl_d & ~r.sda_d & r.sda_s;

      // Read mux; reserved status bits and unmapped pointers read as zero.
      case (r.ptr)
         CHANNEL_ALARM_STATUS_OFS:    rd_data = r.chan_status;
         MISC_ALARM_STATUS_OFS:       rd_data = {2'h0, r.misc_status[MISC_USED_W-1:0]};
         CHANNEL_ALARM_MASK_OFS:      rd_data = r.chan_mask;
         MISC_ALARM_MASK_OFS:         rd_data = r.misc_mask;
         TACH_DIVISOR_PIN_CONFIG_OFS: rd_data = r.tach_cfg;
         default:                     rd_data = BYTE_ZERO;
      endcase

      // Two-wire slave. Data is sampled on SCL rise and changed after SCL fall.
      if (bus_start) begin
         next_r.state     = BUS_ADDR;
         next_r.bit_cnt   = 3'h0;
         next_r.byte_done = 1'b0;
         next_r.sda_oe    = 1'b0;
      end else if (bus_stop) begin
         next_r.state  = BUS_IDLE;
         next_r.sda_oe = 1'b0;
      end else begin
         if (scl_rise) begin
            case (r.state)
               BUS_ADDR, BUS_REG, BUS_WDATA, BUS_RDATA: begin
                  next_r.rx      = {r.rx[6:0], r.sda_s};
                  next_r.bit_cnt = r.bit_cnt + 3'h1;
                  if (r.bit_cnt == 3'h7) begin
                     next_r.byte_done = 1'b1;
                  end
               end
               BUS_RDATA_ACK: next_r.master_ack = ~r.sda_s;
               default: ;
            endcase
         end
         if (scl_fall) begin
            case (r.state)
               BUS_ADDR: begin
                  if (r.byte_done) begin
                     next_r.byte_done = 1'b0;
                     if (r.rx[7:1] == {SLAVE_ADDR_PREFIX, r.addr_s}) begin
                        next_r.state  = BUS_ADDR_ACK;
                        next_r.rw     = r.rx[0];
                        next_r.sda_oe = 1'b1;
                     end else begin
                        next_r.state = BUS_IDLE;
                     end
                  end
               end
               BUS_ADDR_ACK: begin
                  if (r.rw) begin
                     do_load = 1'b1;
                  end else begin
                     next_r.state  = BUS_REG;
                     next_r.sda_oe = 1'b0;
                  end
               end
               BUS_REG: begin
                  if (r.byte_done) begin
                     next_r.byte_done = 1'b0;
                     next_r.ptr       = r.rx;
                     next_r.state     = BUS_REG_ACK;
                     next_r.sda_oe    = 1'b1;
                  end
               end
               BUS_REG_ACK, BUS_WDATA_ACK: begin
                  next_r.state  = BUS_WDATA;
                  next_r.sda_oe = 1'b0;
               end
               BUS_WDATA: begin
                  if (r.byte_done) begin
                     next_r.byte_done = 1'b0;
                     next_r.state     = BUS_WDATA_ACK;
                     next_r.sda_oe    = 1'b1;
                     case (r.ptr)
                        CHANNEL_ALARM_MASK_OFS:      next_r.chan_mask = r.rx;
                        MISC_ALARM_MASK_OFS:         next_r.misc_mask = r.rx;
                        TACH_DIVISOR_PIN_CONFIG_OFS: next_r.tach_cfg  = r.rx;
                        default: ;
                     endcase
                  end
               end
               BUS_RDATA: begin
                  if (r.byte_done) begin
                     next_r.byte_done = 1'b0;
                     next_r.state     = BUS_RDATA_ACK;
                     next_r.sda_oe    = 1'b0;
                  end else begin
                     next_r.tx     = {r.tx[6:0], 1'b0};
                     next_r.sda_oe = ~r.tx[6];
                  end
               end
               BUS_RDATA_ACK: begin
                  if (r.master_ack) begin
                     do_load = 1'b1;
                  end else begin
                     next_r.state = BUS_IDLE;
                  end
               end
               default: next_r.state = BUS_IDLE;
            endcase
         end
      end

      // Loading a status byte for the host clears it, which is why it latches.
      if (do_load) begin
         next_r.tx      = rd_data;
         next_r.sda_oe  = ~rd_data[7];
         next_r.state   = BUS_RDATA;
         next_r.bit_cnt = 3'h0;
         clr_chan = (r.ptr == CHANNEL_ALARM_STATUS_OFS);
         clr_misc = (r.ptr == MISC_ALARM_STATUS_OFS);
      end

      // Source events; nothing is latched while monitoring is paused.
      hot_one_time = r.misc_mask[ALARM_MODE_BIT];
      ot_one_time  = r.misc_mask[OVERTEMP_MODE_BIT];
      next_r.hot_prev = hot_temp_exceed_i;
      next_r.ot_prev  = overtemp_exceed_i;
      if (!alarm_clear_i) begin
         chan_ev[CHANNEL_COUNT-1:0] = channel_exceed_i;
         chan_ev[EXT_ALARM_BIT]     = ~r.ext_s;
         // One-time reports the rising edge only; default reports the level.
         misc_ev[HOT_BIT] = hot_one_time ? (hot_temp_exceed_i & ~r.hot_prev)
                                         : hot_temp_exceed_i;
         misc_ev[DIGITAL_BIT] = ~r.dig_s;
         misc_ev[TACH_INPUT_1_BIT] = r.tach_cfg[TACH1_MODE_BIT]
                           ? tach_level_active(r.tach_cfg[TACH1_CODE_LO +: 2], r.tach1_s)
                           : tach_input_1_count_exceed_i;
         misc_ev[TACH_INPUT_2_BIT] = r.tach_cfg[TACH2_MODE_BIT]
                           ? tach_level_active(r.tach_cfg[TACH2_CODE_LO +: 2], r.tach2_s)
                           : tach_input_2_count_exceed_i;
         misc_ev[CHASSIS_BIT] = r.chas_s;
         misc_ev[OVERTEMP_BIT] = ot_one_time ? (overtemp_exceed_i & ~r.ot_prev)
                                             : overtemp_exceed_i;
      end

      // Sticky flags: an event in the clearing cycle wins over the clear.
      next_r.chan_status = (r.chan_status & ~{8{clr_chan}}) | chan_ev;
      next_r.misc_status = (r.misc_status & ~{8{clr_misc}}) | misc_ev;
      next_r.misc_status[7:MISC_USED_W] = 2'h0;

      // Alarm output from the unmasked status bits.
      alarm_pending = |(r.chan_status & ~r.chan_mask)
                    | |(r.misc_status[MISC_USED_W-1:0]
                        & ~r.misc_mask[MISC_USED_W-1:0]);
      next_r.alarm_oe  = alarm_out_enable_i & ~alarm_clear_i & alarm_pending;
      next_r.alarm_out = alarm_polarity_i;
      next_r.pause     = alarm_clear_i;

      // Shared active-low open-drain pin; in one-time mode it follows the flag.
      ot_assert = ot_one_time ? r.misc_status[OVERTEMP_BIT] : overtemp_exceed_i;
      case ({r.tach_cfg[RESET_PIN_SELECT_BIT], r.tach_cfg[OVERTEMP_PIN_SELECT_BIT]})
         2'h1:    next_r.shared_oe = ot_assert;
         2'h2:    next_r.shared_oe = reset_out_request_i;
         default: next_r.shared_oe = 1'b0;
      endcase
      next_r.sda_out = 1'b0;
   end

   // State register; every control bit takes a constant under reset.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         r <= '0;
         r.state       <= BUS_IDLE;
         r.scl_m       <= 1'b1;
         r.scl_s       <= 1'b1;
         r.scl_d       <= 1'b1;
         r.sda_m       <= 1'b1;
         r.sda_s       <= 1'b1;
         r.sda_d       <= 1'b1;
         r.ext_m       <= 1'b1;
         r.ext_s       <= 1'b1;
         r.dig_m       <= 1'b1;
         r.dig_s       <= 1'b1;
         r.chan_status <= STATUS_RST;
         r.misc_status <= STATUS_RST;
         r.chan_mask   <= MASK_RST;
         r.misc_mask   <= MASK_RST;
         r.tach_cfg    <= TACH_CFG_RST;
      end else begin
         r <= next_r;
      end
   end

   // Outputs come straight from the state register.
   assign sda_o           = r.sda_out;
   assign sda_oe_o        = r.sda_oe;
   assign alarm_o         = r.alarm_out;
   assign alarm_oe_o      = r.alarm_oe;
   assign shared_pin_o    = r.sda_out;
   assign shared_pin_oe_o = r.shared_oe;
   assign monitor_pause_o = r.pause;
   assign tach_mode_o     = {r.tach_cfg[TACH2_MODE_BIT], r.tach_cfg[TACH1_MODE_BIT]};
   assign tach1_code_o    = r.tach_cfg[TACH1_CODE_LO +: 2];
   assign tach2_code_o    = r.tach_cfg[TACH2_CODE_LO +: 2];

endmodule // mashm_top

// ==== logic/mashm_pkg.sv ====
package mashm_pkg;

   // Register pointer values seen on the two-wire port.
   localparam logic [7:0] CHANNEL_ALARM_STATUS_OFS    = 8'h01;
   localparam logic [7:0] MISC_ALARM_STATUS_OFS       = 8'h02;
   localparam logic [7:0] CHANNEL_ALARM_MASK_OFS      = 8'h03;
   localparam logic [7:0] MISC_ALARM_MASK_OFS         = 8'h04;
   localparam logic [7:0] TACH_DIVISOR_PIN_CONFIG_OFS = 8'h05;

   // Reset values.
   localparam logic [7:0] STATUS_RST    = 8'h00;
   localparam logic [7:0] MASK_RST      = 8'h00;
   localparam logic [7:0] TACH_CFG_RST  = 8'h14;
   localparam logic [7:0] BYTE_ZERO     = 8'h00;

   // Fixed upper four bits of the slave address; the low three come from pins.
   localparam logic [3:0] SLAVE_ADDR_PREFIX = 4'h5;

   // Field positions of the status and mask registers.
   localparam int CHANNEL_COUNT   = 7;
   localparam int EXT_ALARM_BIT   = 7;
   localparam int HOT_BIT         = 0;
   localparam int DIGITAL_BIT     = 1;
   localparam int TACH_INPUT_1_BIT        = 2;
   localparam int TACH_INPUT_2_BIT        = 3;
   localparam int CHASSIS_BIT     = 4;
   localparam int OVERTEMP_BIT    = 5;
   localparam int MISC_USED_W     = 6;
   localparam int ALARM_MODE_BIT  = 6;
   localparam int OVERTEMP_MODE_BIT = 7;

   // Field positions of the tachometer configuration register.
   localparam int TACH1_MODE_BIT     = 0;
   localparam int TACH2_MODE_BIT     = 1;
   localparam int TACH1_CODE_LO      = 2;
   localparam int TACH2_CODE_LO      = 4;
   localparam int OVERTEMP_PIN_SELECT_BIT = 6;
   localparam int RESET_PIN_SELECT_BIT    = 7;

   // Level-mode code that makes a tachometer pin active low.
   localparam logic [1:0] TACH_LEVEL_ACTIVE_LOW = 2'h1;

   typedef enum logic [3:0] {
      BUS_IDLE,
      BUS_ADDR,
      BUS_ADDR_ACK,
      BUS_REG,
      BUS_REG_ACK,
      BUS_WDATA,
      BUS_WDATA_ACK,
      BUS_RDATA,
      BUS_RDATA_ACK
   } mashm_bus_state_type;

endpackage

// ==== verification/mashm_asserts.sv ====
`timescale 1ns/1ps
// Pin-level checks of the alarm block; sees only the top-level ports.
module mashm_asserts (
   input wire logic       mclk_i,
   input wire logic       rst_i,
   input wire logic       scl_i,
   input wire logic       sda_o,
   input wire logic       sda_oe_o,
   input wire logic       alarm_out_enable_i,
   input wire logic       alarm_polarity_i,
   input wire logic       alarm_clear_i,
   input wire logic       overtemp_exceed_i,
   input wire logic       reset_out_request_i,
   input wire logic       alarm_o,
   input wire logic       alarm_oe_o,
   input wire logic       shared_pin_o,
   input wire logic       shared_pin_oe_o,
   input wire logic       monitor_pause_o,
   input wire logic [1:0] tach_mode_o,
   input wire logic [1:0] tach1_code_o,
   input wire logic [1:0] tach2_code_o
);
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   logic [7:0] quiet;
   logic       scl_q;
   // Counts cycles since the bus clock moved; starts at zero so reset loading is allowed.
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         quiet <= 8'h00;
         scl_q <= 1'b1;
      end else begin
         scl_q <= scl_i;
         quiet <= (scl_i != scl_q) ? 8'h00 : quiet + {7'h00, quiet != 8'hff};
      end
   end
   a_alarm_gate: assert property (
      alarm_oe_o |-> $past(alarm_out_enable_i && !alarm_clear_i))
      else $error("Alarm driven while disabled or cleared.");
   a_alarm_level: assert property (
      alarm_oe_o |-> alarm_o == $past(alarm_polarity_i))
      else $error("Alarm drive level differs from polarity.");
   a_pause_follow: assert property (
      monitor_pause_o == $past(alarm_clear_i))
      else $error("Pause flag does not follow clear.");
   a_clear_quiet: assert property (
      alarm_clear_i ##1 alarm_clear_i |-> !alarm_oe_o)
      else $error("Alarm driven while clear held.");
   a_sda_scl_low: assert property (
      $changed(sda_oe_o) |-> !scl_i)
      else $error("Data line moved while bus clock high.");
   a_sda_open: assert property (
      sda_oe_o |-> !sda_o)
      else $error("Data line driven high.");
   a_cfg_bus_only: assert property (
      $changed({tach_mode_o, tach1_code_o, tach2_code_o}) |-> quiet < 8'h28)
      else $error("Tach settings changed without bus traffic.");
   a_shared_cause: assert property (
      $rose(shared_pin_oe_o) |-> !shared_pin_o && ($past(overtemp_exceed_i)
         || $past(overtemp_exceed_i, 2) || $past(reset_out_request_i)))
      else $error("Shared pin pulled without a cause.");
   c_alarm: cover property ($rose(alarm_oe_o));
   c_shared: cover property ($rose(shared_pin_oe_o));
   c_ack: cover property ($rose(sda_oe_o) ##[1:200] $fell(sda_oe_o));
endmodule // mashm_asserts

// ==== verification/mashm_host.sv ====
`timescale 1ns/1ps
// Two-wire bus master; a released data line reads high through the pull-up.
module mashm_host
   import mashm_pkg::*;
#(
   parameter logic [2:0] SLAVE = 3'h0
) (
   input  wire logic mclk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_o
);
   // Idle bus at time zero.
   initial begin
      scl_o = 1'b1;
      sda_o = 1'b1;
   end
   task automatic t(input int n);
      repeat (n) @(posedge mclk_i);
   endtask
   // Data moves only mid-low, so the slave never sees a false start or stop.
   task automatic bitx(input logic b, output logic s);
      scl_o <= 1'b0;
      t(4);
      sda_o <= b;
      t(4);
      scl_o <= 1'b1;
      t(6);
      s = sda_i;
      t(2);
   endtask
   // Start also serves as repeated start after an acknowledge.
   task automatic start();
      scl_o <= 1'b0;
      t(4);
      sda_o <= 1'b1;
      t(4);
      scl_o <= 1'b1;
      t(8);
      sda_o <= 1'b0;
      t(8);
   endtask
   task automatic stop();
      scl_o <= 1'b0;
      t(4);
      sda_o <= 1'b0;
      t(4);
      scl_o <= 1'b1;
      t(8);
      sda_o <= 1'b1;
      t(8);
   endtask
   task automatic sbyte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) bitx(d[i], s);
      bitx(1'b1, s);
      ack = !s;
   endtask
   // Address, pointer, one data byte; bad flips an address bit.
   task automatic wr(input logic [7:0] p, d, input logic bad, output logic ok);
      logic a0, a1, a2;
      start();
      sbyte({SLAVE_ADDR_PREFIX, SLAVE ^ {2'h0, bad}, 1'b0}, a0);
      sbyte(p, a1);
      sbyte(d, a2);
      stop();
      ok = a0 & a1 & a2;
   endtask
   // Pointer write, repeated start, one byte read, then a not-acknowledge.
   task automatic rd(input logic [7:0] p, output logic [7:0] d);
      logic a, s;
      start();
      sbyte({SLAVE_ADDR_PREFIX, SLAVE, 1'b0}, a);
      sbyte(p, a);
      start();
      sbyte({SLAVE_ADDR_PREFIX, SLAVE, 1'b1}, a);
      for (int i = 0; i < 8; i++) begin
         bitx(1'b1, s);
         d = {d[6:0], s};
      end
      bitx(1'b1, s);
      stop();
   endtask
endmodule // mashm_host

// ==== verification/monitor_alarm_status_mask_tb.sv ====
`timescale 1ns/1ps
module monitor_alarm_status_mask_tb;
   import mashm_pkg::*;
   logic        clk, rst, scl, hsda, sda_do, sda_oe, t1, t2, en, pol, clr, rreq;
   logic        al, al_oe, sp, sp_oe, pause;
   logic [1:0]  tmode, t1c, t2c;
   logic [15:0] evv;
   logic [31:0] seed = 32'hdbf849ab;
   wire         sda_w = hsda & ~sda_oe;
   int          err_count, tests_run, cycles, st1, st2, m1, m2, cfg;
   mashm_host #(.SLAVE(3'h5)) host_u (.mclk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(hsda));
   mashm_top dut_u (.mclk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_do),
      .sda_oe_o(sda_oe), .addr_pins_i(3'h5), .channel_exceed_i(evv[6:0]),
      .ext_alarm_n_i(!evv[7]), .hot_temp_exceed_i(evv[8]), .overtemp_exceed_i(evv[13]),
      .tach_input_1_count_exceed_i(evv[10]), .tach_input_2_count_exceed_i(evv[11]),
      .digital_sensor_alert_input_n_i(!evv[9]), .chassis_intrusion_input_i(evv[12]),
      .tach_input_1_i(t1), .tach_input_2_i(t2), .alarm_out_enable_i(en),
      .alarm_polarity_i(pol), .alarm_clear_i(clr), .reset_out_request_i(rreq),
      .alarm_o(al), .alarm_oe_o(al_oe), .shared_pin_o(sp), .shared_pin_oe_o(sp_oe),
      .monitor_pause_o(pause), .tach_mode_o(tmode), .tach1_code_o(t1c), .tach2_code_o(t2c));
   // Free-running clock.
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   function logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("BAD %s exp %h got %h", nm, e, g);
         err_count++;
      end
   endtask
   task automatic done(input string nm);
      $display("test %s done", nm);
   endtask
   task give_verdict();
      $display("checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Register write through the host; the model follows what the block must hold.
   task automatic wm(input logic [7:0] p, d);
      logic ok;
      host_u.wr(p, d, 1'b0, ok);
      chk("ack", 8'h01, 8'(ok));
      if (p == 8'h03) m1 = d;
      if (p == 8'h04) m2 = d;
      if (p == 8'h05) cfg = d;
   endtask
   // Status registers empty on read, so the model clears them too.
   task automatic rm(input logic [7:0] p);
      logic [7:0] e, g;
      e = (p == 1) ? 8'(st1) : (p == 2) ? 8'(st2) : (p == 3) ? 8'(m1) :
          (p == 4) ? 8'(m2) : (p == 5) ? 8'(cfg) : 8'h00;
      host_u.rd(p, g);
      if (p == 8'h01) st1 = 0;
      if (p == 8'h02) st2 = 0;
      chk("reg", e, g);
   endtask
   // Pulse events; the model only latches them while monitoring runs.
   task automatic ev(input logic [7:0] a, b);
      evv <= {b, a};
      cyc(6);
      evv <= 16'h0000;
      cyc(6);
      if (!clr) begin
         st1 |= a;
         st2 |= b & 8'h3f;
      end
   endtask
   task automatic ca();
      logic e;
      cyc(4);
      e = en && !clr && ((st1 & ~m1) | (st2 & ~m2 & 32'h3f)) != 0;
      chk("alarm_oe", 8'(e), 8'(al_oe));
      if (e) chk("alarm_o", 8'(pol), 8'(al));
   endtask
   // Bounded run length; a hang counts as a mismatch.
   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         err_count++;
         give_verdict();
      end
   end
   initial begin
      logic [7:0] d;
      logic       ok;
      logic [7:0] pins [4];
      // Shared pin settings: overtemp, reset, both (off), none (off).
      pins = '{8'h40, 8'h80, 8'hc0, 8'h00};
      {rst, evv, t1, t2, en, pol, clr, rreq} = {1'b1, 16'h0, 6'h20};
      {st1, st2, m1, m2, cfg} = {32'd0, 32'd0, 32'd0, 32'd0, 32'h14};
      cyc(10);
      rst <= 1'b0;
      cyc(6);
      rm(8'h03);
      rm(8'h04);
      rm(8'h05);
      chk("codes", 8'h05, {2'h0, tmode, t2c, t1c});
      rm(8'h01);
      rm(8'h02);
      done("reset");
      for (logic [7:0] p = 8'h03; p <= 8'h05; p++) begin
         d = 8'(rnd());
         if (p == 8'h05) d[1:0] = 2'h0;
         wm(p, d);
         rm(p);
      end
      chk("codes", {2'h0, d[1:0], d[5:4], d[3:2]}, {2'h0, tmode, t2c, t1c});
      wm(8'h01, 8'hff);
      rm(8'h01);
      rm(8'h06);
      host_u.wr(8'h03, 8'h5a, 1'b1, ok);
      chk("nak", 8'h00, 8'(ok));
      rm(8'h03);
      wm(8'h03, 8'h00);
      wm(8'h04, 8'h00);
      wm(8'h05, 8'h00);
      done("regs");
      // The external alarm bit is forced so that its path is always exercised.
      ev(8'(rnd()) | 8'h80, 8'h00);
      rm(8'h01);
      ev(8'h00, 8'h3f);
      rm(8'h02);
      rm(8'h02);
      wm(8'h05, 8'h07);
      {t1, t2} <= 2'b01;
      cyc(6);
      {t1, t2} <= 2'b10;
      cyc(6);
      st2 = 8'h0c;
      rm(8'h02);
      wm(8'h05, 8'h00);
      done("events");
      en <= 1'b1;
      pol <= 1'(rnd());
      ev(8'h01, 8'h00);
      ca();
      wm(8'h03, 8'h01);
      ca();
      ev(8'h00, 8'h01);
      ca();
      wm(8'h04, 8'h01);
      ca();
      wm(8'h03, 8'h00);
      clr <= 1'b1;
      ev(8'h02, 8'h00);
      ca();
      chk("pause", 8'h01, 8'(pause));
      clr <= 1'b0;
      ca();
      en <= 1'b0;
      ca();
      rm(8'h01);
      rm(8'h02);
      wm(8'h04, 8'h00);
      done("alarm");
      // Conditions held across two reads: one-time mode must not report twice.
      for (int m = 0; m < 2; m++) begin
         wm(8'h04, m ? 8'hc0 : 8'h00);
         evv <= 16'h2100;
         cyc(6);
         st2 = 8'h21;
         rm(8'h02);
         st2 = m ? 0 : 8'h21;
         rm(8'h02);
         evv <= 16'h0000;
         cyc(6);
         st2 = m ? 0 : 8'h21;
         rm(8'h02);
      end
      wm(8'h04, 8'h00);
      done("modes");
      foreach (pins[i]) begin
         wm(8'h05, pins[i]);
         for (int k = 0; k < 2; k++) begin
            evv <= k ? 16'h0000 : 16'h2000;
            rreq <= k;
            cyc(4);
            chk("shared", 8'(pins[i] == (k ? 8'h80 : 8'h40)), 8'(sp_oe));
            evv <= 16'h0000;
            rreq <= 1'b0;
            cyc(4);
         end
      end
      done("shared");
      give_verdict();
   end
endmodule // monitor_alarm_status_mask_tb

bind mashm_top mashm_asserts chk_u (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl_i),
   .sda_o(sda_o), .sda_oe_o(sda_oe_o), .alarm_out_enable_i(alarm_out_enable_i),
   .alarm_polarity_i(alarm_polarity_i), .alarm_clear_i(alarm_clear_i),
   .overtemp_exceed_i(overtemp_exceed_i), .reset_out_request_i(reset_out_request_i),
   .alarm_o(alarm_o), .alarm_oe_o(alarm_oe_o), .shared_pin_o(shared_pin_o),
   .shared_pin_oe_o(shared_pin_oe_o), .monitor_pause_o(monitor_pause_o),
   .tach_mode_o(tach_mode_o), .tach1_code_o(tach1_code_o), .tach2_code_o(tach2_code_o));
